// *** irpc_pkg.sv ***
// Constants shared by the IR pulse and carrier detect block
package irpc_pkg;

  // ==========================================================
  // Register byte offsets
  localparam logic [11:0] OFS_CTRL_ONE = 12'h00a0;
  localparam logic [11:0] OFS_CTRL_TWO = 12'h00a4;
  localparam logic [11:0] OFS_HOLD     = 12'h00a8;
  localparam logic [11:0] OFS_STATUS   = 12'h00ac;

  // ==========================================================
  // Control one field positions
  localparam int BIT_CONS_EN  = 0;
  localparam int BIT_MACH_EN  = 1;
  localparam int BIT_RX_PWR   = 2;
  localparam int BIT_INVERT   = 3;
  localparam int BIT_TEST     = 4;
  localparam int POS_PRESCALE = 16;
  localparam int BIT_CARRIER  = 24;

  // Control two field positions
  localparam int POS_WAIT     = 0;
  localparam int POS_DELAY    = 8;
  localparam int POS_PULSE_ON_VALUE   = 16;
  localparam int POS_PERIOD   = 24;

  // Status bit positions (write one to clear)
  localparam int STS_HOLD_EMPTY = 0;
  localparam int STS_SAMPLE     = 1;
  localparam int STS_RISE       = 2;
  localparam int STS_FALL       = 3;

  // ==========================================================
  // Values after reset
  localparam logic [7:0]  RST_BYTE = 8'h00;
  localparam logic [15:0] RST_HOLD = 16'h0000;
  localparam logic [3:0]  RST_STS  = 4'h0;

  // ==========================================================
  // Timing
  localparam int CLK_HZ  = 100000000;
  localparam int BAUD_HZ = 3686400;
  // Phase step and modulus of the baud tick accumulator
  localparam logic [20:0] BAUD_STEP = 21'(BAUD_HZ / 100);
  localparam logic [20:0] BAUD_MOD  = 21'(CLK_HZ / 100);
  // Slow clock edges per carrier tick (32.768 kHz gives 7.8 ms)
  localparam int SLOW_DIV_DEFAULT = 256;

endpackage

// *** irpc_pulse_gen.sv ***
// Consumer remote pulse shaper driven by the prescaled tick
`timescale 1ns/1ps
`default_nettype none
module irpc_pulse_gen (
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_enable,
  input  wire logic        i_tick,
  input  wire logic [7:0]  i_period,
  input  wire logic [7:0]  i_pulse_on_value,
  input  wire logic [15:0] i_hold,
  output var  logic        o_out,
  output var  logic        o_hold_empty
);
  typedef struct packed {
    logic [7:0] per_cnt;
    logic [7:0] on_cnt;
    logic [6:0] num;
    logic       onoff;
    logic [7:0] inter;
    logic       lower_next;
    logic       out;
    logic       empty;
  } irpc_pg_t;

  irpc_pg_t st;
  irpc_pg_t next_st;

  always_comb begin
    next_st = st;
    next_st.empty = 1'b0;
    if (!i_enable) begin
      next_st = '0;
    end else if (i_tick) begin
      if (st.per_cnt == 8'h00) begin
        next_st.per_cnt = i_period;
        next_st.on_cnt  = i_pulse_on_value;
        if (st.num <= 7'h01) begin
          if (!st.lower_next) begin
            next_st.num        = i_hold[14:8];
            next_st.onoff      = i_hold[15];
            next_st.inter      = i_hold[7:0];
            next_st.empty      = 1'b1;
            next_st.lower_next = 1'b1;
          end else begin
            next_st.num        = st.inter[6:0];
            next_st.onoff      = st.inter[7];
            next_st.lower_next = 1'b0;
          end
        end else begin
          next_st.num = st.num - 7'h01;
        end
      end else begin
        next_st.per_cnt = st.per_cnt - 8'h01;
        // Frozen at zero so the line cannot rise again this period
        if (st.on_cnt != 8'h00) begin
          next_st.on_cnt = st.on_cnt - 8'h01;
        end
      end
    end
    // High while on time runs; an off segment stays low
    next_st.out = next_st.onoff && (next_st.on_cnt != 8'h00);
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign o_out        = st.out;
  assign o_hold_empty = st.empty;
endmodule
`default_nettype wire

// *** irpc_carrier_fsm.sv ***
// Carrier detect machine: powers the receiver and samples it
`timescale 1ns/1ps
`default_nettype none
module irpc_carrier_fsm (
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  input  wire logic       i_enable,
  input  wire logic       i_tick,
  input  wire logic [7:0] i_delay,
  input  wire logic [7:0] i_wait,
  input  wire logic       i_carrier,
  output var  logic       o_rx_pwr,
  output var  logic       o_sample_hit
);
  typedef struct packed {
    logic [7:0] dly;
    logic [7:0] wt;
    logic       pwr;
    logic       hit;
  } irpc_cf_t;

  irpc_cf_t st;
  irpc_cf_t next_st;

  always_comb begin
    next_st = st;
    next_st.hit = 1'b0;
    if (!i_enable) begin
      next_st = '0;
    end else if (i_tick) begin
      if (st.dly == 8'h00) begin
        next_st.dly = i_delay;
        if (st.wt == 8'h00) begin
          next_st.wt  = i_wait;
          next_st.pwr = 1'b0;
          next_st.hit = st.pwr && i_carrier;
        end else begin
          next_st.wt  = st.wt - 8'h01;
          next_st.pwr = (st.wt == 8'h01);
        end
      end else begin
        next_st.dly = st.dly - 8'h01;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign o_rx_pwr     = st.pwr;
  assign o_sample_hit = st.hit;
endmodule
`default_nettype wire

// *** irpc_top.sv ***
// Top of the IR pulse generator and carrier detect block
//
// How it works
// - Pulse generator idle until consumer enable set
// - Baud clock divided by 8-bit prescale
// - Cycle length sets ticks per period
// - On value sets high ticks per period
// - Holding word: two segments, flag plus count
// - Counter empty loads upper byte and flag
// - Output high until on counter ends, frozen
// - Then lower byte loads counter and flag
// - Off flag keeps output low for periods
// - Upper load moves lower byte, flags empty
// - Delay counter reloads at zero, 7.8 ms
// - Delay terminal steps wait counter, reloads
// - Receiver power asserts at wait zero
// - Power drops at next wait step
// - Sample carrier at power drop, flag if 1
// - Flag every carrier rise
// - Flag every carrier fall
// - Invert bit makes output active low
// - Machine enable gates receiver power counters
`timescale 1ns/1ps
`default_nettype none
module irpc_top #(
  parameter int SLOW_DIV = irpc_pkg::SLOW_DIV_DEFAULT
) (
  input  wire logic        i_clk,
  input  wire logic        i_reset_n,
  input  wire logic [11:0] i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output var  logic [31:0] o_rdata,
  input  wire logic        i_carrier_present_input,
  input  wire logic        i_slow_clk,
  output var  logic        o_ir_output_pin,
  output var  logic        o_receiver_power_pin,
  output var  logic        o_holding_empty_irq,
  output var  logic        o_carrier_sample_irq,
  output var  logic        o_carrier_rise_irq,
  output var  logic        o_carrier_fall_irq
);

  // ==========================================================
  // Reset release
  logic [1:0] rst_sync;
  logic       rst_n;

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rst_sync <= 2'b00;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end

  assign rst_n = rst_sync[1];

  // ==========================================================
  // State
  typedef struct packed {
    logic        cons_en;
    logic        mach_en;
    logic        rx_manual;
    logic        invert;
    logic        test;
    logic [7:0]  prescale;
    logic [7:0]  period;
    logic [7:0]  pulse_on_value;
    logic [7:0]  delay;
    logic [7:0]  waitv;
    logic [15:0] hold;
    logic [3:0]  sts;
    logic [31:0] rdata;
    logic        cd_s0;
    logic        cd_s1;
    logic        cd_s2;
    logic        sc_s0;
    logic        sc_s1;
    logic        sc_s2;
    logic [19:0] acc;
    logic [7:0]  pre;
    logic        ptick;
    logic [15:0] slow_cnt;
    logic        ctick;
    logic        ir;
    logic        rxp;
  } irpc_top_t;

  irpc_top_t st;
  irpc_top_t next_st;

  logic        pg_out;
  logic        pg_empty;
  logic        cf_pwr;
  logic        cf_hit;
  logic [20:0] acc_sum;
  logic        baud_tick;
  logic [3:0]  set_bits;

  // ==========================================================
  // Submodules
  irpc_pulse_gen u_pulse (
    .i_clk        (i_clk),
    .i_rst_n      (rst_n),
    .i_enable     (st.cons_en),
    .i_tick       (st.ptick),
    .i_period     (st.period),
    .i_pulse_on_value     (st.pulse_on_value),
    .i_hold       (st.hold),
    .o_out        (pg_out),
    .o_hold_empty (pg_empty)
  );

  irpc_carrier_fsm u_carrier (
    .i_clk        (i_clk),
    .i_rst_n      (rst_n),
    .i_enable     (st.mach_en),
    .i_tick       (st.ctick),
    .i_delay      (st.delay),
    .i_wait       (st.waitv),
    .i_carrier    (st.cd_s1),
    .o_rx_pwr     (cf_pwr),
    .o_sample_hit (cf_hit)
  );

  // ==========================================================
  // Register read data
  function automatic logic [31:0] read_word(input irpc_top_t s,
                                            input logic [11:0] a);
    logic [31:0] w;
    w = 32'h0000_0000;
    if (a == irpc_pkg::OFS_CTRL_ONE) begin
      w[irpc_pkg::BIT_CONS_EN] = s.cons_en;
      w[irpc_pkg::BIT_MACH_EN] = s.mach_en;
      w[irpc_pkg::BIT_RX_PWR]  = s.rx_manual;
      w[irpc_pkg::BIT_INVERT]  = s.invert;
      w[irpc_pkg::BIT_TEST]    = s.test;
      w[irpc_pkg::POS_PRESCALE +: 8] = s.prescale;
      w[irpc_pkg::BIT_CARRIER] = s.cd_s1;
    end else if (a == irpc_pkg::OFS_STATUS) begin
      w[3:0] = s.sts;
    end
    // Control two and holding are write-only and read zero
    return w;
  endfunction

  // ==========================================================
  // Next state
  always_comb begin
    next_st = st;
    acc_sum = 21'h00_0000;
    baud_tick = 1'b0;
    set_bits = 4'h0;

    // Pins pass two flip-flops before any logic reads them
    next_st.cd_s0 = i_carrier_present_input;
    next_st.cd_s1 = st.cd_s0;
    next_st.cd_s2 = st.cd_s1;
    next_st.sc_s0 = i_slow_clk;
    next_st.sc_s1 = st.sc_s0;
    next_st.sc_s2 = st.sc_s1;

    // Baud tick at 3.6864 MHz on average; jitter is one cycle
    acc_sum = {1'b0, st.acc} + irpc_pkg::BAUD_STEP;
    if (acc_sum >= irpc_pkg::BAUD_MOD) begin
      acc_sum = acc_sum - irpc_pkg::BAUD_MOD;
      baud_tick = 1'b1;
    end
    next_st.acc = acc_sum[19:0];
    // Test mode puts the baud and carrier ticks on every clock
    if (st.test) begin
      baud_tick = 1'b1;
    end

    // Prescaler gives one tick every prescale+1 baud ticks
    next_st.ptick = 1'b0;
    if (!st.cons_en) begin
      next_st.pre = irpc_pkg::RST_BYTE;
    end else if (baud_tick) begin
      if (st.pre == 8'h00) begin
        next_st.pre   = st.prescale;
        next_st.ptick = 1'b1;
      end else begin
        next_st.pre = st.pre - 8'h01;
      end
    end

    // Carrier tick from rising slow clock edges
    next_st.ctick = 1'b0;
    if (st.test) begin
      next_st.ctick = 1'b1;
    end else if (st.sc_s1 && !st.sc_s2) begin
      if (st.slow_cnt == 16'(SLOW_DIV - 1)) begin
        next_st.slow_cnt = 16'h0000;
        next_st.ctick    = 1'b1;
      end else begin
        next_st.slow_cnt = st.slow_cnt + 16'h0001;
      end
    end

    // Event flags
    set_bits[irpc_pkg::STS_HOLD_EMPTY] = pg_empty;
    set_bits[irpc_pkg::STS_SAMPLE]     = cf_hit;
    set_bits[irpc_pkg::STS_RISE] = st.cd_s1 && !st.cd_s2;
    set_bits[irpc_pkg::STS_FALL] = !st.cd_s1 && st.cd_s2;

    // Register writes
    if (i_wr) begin
      if (i_addr == irpc_pkg::OFS_CTRL_ONE) begin
        next_st.cons_en   = i_wdata[irpc_pkg::BIT_CONS_EN];
        next_st.mach_en   = i_wdata[irpc_pkg::BIT_MACH_EN];
        next_st.rx_manual = i_wdata[irpc_pkg::BIT_RX_PWR];
        next_st.invert    = i_wdata[irpc_pkg::BIT_INVERT];
        next_st.test      = i_wdata[irpc_pkg::BIT_TEST];
        next_st.prescale  = i_wdata[irpc_pkg::POS_PRESCALE +: 8];
      end else if (i_addr == irpc_pkg::OFS_CTRL_TWO) begin
        next_st.period = i_wdata[irpc_pkg::POS_PERIOD +: 8];
        next_st.pulse_on_value = i_wdata[irpc_pkg::POS_PULSE_ON_VALUE +: 8];
        next_st.delay  = i_wdata[irpc_pkg::POS_DELAY +: 8];
        next_st.waitv  = i_wdata[irpc_pkg::POS_WAIT +: 8];
      end else if (i_addr == irpc_pkg::OFS_HOLD) begin
        next_st.hold = i_wdata[15:0];
      end else if (i_addr == irpc_pkg::OFS_STATUS) begin
        next_st.sts = st.sts & ~i_wdata[3:0];
      end
    end
    // A flag raised in the clearing cycle survives
    next_st.sts = next_st.sts | set_bits;

    // Read data stands in the cycle after the strobe only
    if (i_rd) begin
      next_st.rdata = read_word(st, i_addr);
    end else begin
      next_st.rdata = 32'h0000_0000;
    end

    // Pins
    next_st.ir  = pg_out ^ st.invert;
    next_st.rxp = cf_pwr | st.rx_manual;
  end

  // ==========================================================
  // Registers
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================
  // Outputs
  assign o_rdata              = st.rdata;
  assign o_ir_output_pin      = st.ir;
  assign o_receiver_power_pin = st.rxp;
  assign o_holding_empty_irq  = st.sts[irpc_pkg::STS_HOLD_EMPTY];
  assign o_carrier_sample_irq = st.sts[irpc_pkg::STS_SAMPLE];
  assign o_carrier_rise_irq   = st.sts[irpc_pkg::STS_RISE];
  assign o_carrier_fall_irq   = st.sts[irpc_pkg::STS_FALL];

endmodule
`default_nettype wire

// *** irpc_checker.sv ***
// Port-level assertions for the IR pulse and carrier detect block
`timescale 1ns/1ps
`default_nettype none
module irpc_checker #(
  parameter int SLOW_DIV = 4
) (
  input wire logic        i_clk,
  input wire logic        i_reset_n,
  input wire logic [11:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic        i_wr,
  input wire logic        i_rd,
  input wire logic [31:0] o_rdata,
  input wire logic        i_carrier_present_input,
  input wire logic        o_ir_output_pin,
  input wire logic        o_receiver_power_pin,
  input wire logic        o_holding_empty_irq,
  input wire logic        o_carrier_sample_irq,
  input wire logic        o_carrier_rise_irq,
  input wire logic        o_carrier_fall_irq
);
  // ==========================================================
  // Shadow of control one, tracked from bus writes
  logic [31:0] c1;
  logic        clr_r;
  logic        clr_e;
  assign clr_r = i_wr && i_addr == irpc_pkg::OFS_STATUS && i_wdata[2];
  assign clr_e = i_wr && i_addr == irpc_pkg::OFS_STATUS && i_wdata[0];
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      c1 <= 32'h0000_0000;
    end else if (i_wr && i_addr == irpc_pkg::OFS_CTRL_ONE) begin
      c1 <= i_wdata;
    end
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  // ==========================================================
  // Assertions
  chk_rdata_after_read: assert property (
    o_rdata != 32'h0000_0000 |-> $past(i_rd))
    else $error("read data without a read");
  chk_idle_level: assert property (
    (!c1[0] && c1 == $past(c1, 3)) |-> o_ir_output_pin == c1[3])
    else $error("idle output level wrong");
  chk_machine_off: assert property (
    (c1[2:1] == 2'b00 && c1 == $past(c1, 3)) |-> !o_receiver_power_pin)
    else $error("receiver power while machine off");
  chk_sample_at_drop: assert property (
    $rose(o_carrier_sample_irq) |-> !o_receiver_power_pin &&
      ($past(o_receiver_power_pin) || $past(o_receiver_power_pin, 2) ||
       $past(o_receiver_power_pin, 3)))
    else $error("sample flag away from power drop");
  chk_rise_seen: assert property (
    $rose(i_carrier_present_input) |-> ##[2:5] o_carrier_rise_irq)
    else $error("carrier rise not flagged");
  chk_fall_seen: assert property (
    $fell(i_carrier_present_input) |-> ##[2:5] o_carrier_fall_irq)
    else $error("carrier fall not flagged");
  chk_rise_cause: assert property (
    $rose(o_carrier_rise_irq) |-> $past(i_carrier_present_input, 3))
    else $error("rise flag without carrier high");
  chk_fall_cause: assert property (
    $rose(o_carrier_fall_irq) |-> !$past(i_carrier_present_input, 3))
    else $error("fall flag without carrier low");
  chk_rise_sticky: assert property (
    (o_carrier_rise_irq && !clr_r) |=> o_carrier_rise_irq)
    else $error("rise flag lost without clear");
  chk_empty_sticky: assert property (
    (o_holding_empty_irq && !clr_e) |=> o_holding_empty_irq)
    else $error("holding empty flag lost without clear");
  chk_empty_cause: assert property (
    $rose(o_holding_empty_irq) |-> c1[0] || $past(c1[0]) ||
      $past(c1[0], 2))
    else $error("holding empty set while disabled");
endmodule
bind irpc_top irpc_checker #(.SLOW_DIV(SLOW_DIV)) chk_u (
  .i_clk(i_clk), .i_reset_n(i_reset_n), .i_addr(i_addr),
  .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
  .i_carrier_present_input(i_carrier_present_input),
  .o_ir_output_pin(o_ir_output_pin),
  .o_receiver_power_pin(o_receiver_power_pin),
  .o_holding_empty_irq(o_holding_empty_irq),
  .o_carrier_sample_irq(o_carrier_sample_irq),
  .o_carrier_rise_irq(o_carrier_rise_irq),
  .o_carrier_fall_irq(o_carrier_fall_irq));
`default_nettype wire

// *** irpc_ir_front.sv ***
// Behavioural model of the external IR receiver front end
`timescale 1ns/1ps
`default_nettype none
module irpc_ir_front #(
  parameter int SETTLE = 2
) (
  input  wire logic i_clk,
  input  wire logic i_rx_pwr,
  input  wire logic i_carrier_on,
  output var  logic o_carrier
);
  // ==========================================================
  // Detector needs time to settle after power-up, so early
  // samples must not see a carrier; unpowered output is pulled low
  int settle_cnt = 0;
  always @(posedge i_clk) begin
    if (!i_rx_pwr) settle_cnt <= 0;
    else if (settle_cnt < SETTLE) settle_cnt <= settle_cnt + 1;
  end
  assign o_carrier = i_rx_pwr && settle_cnt >= SETTLE && i_carrier_on;
endmodule
`default_nettype wire

// *** irpc_tb.sv ***
// Self-checking testbench for the IR pulse and carrier detect block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        i_clk, i_reset_n, i_wr, i_rd, i_slow_clk, carrier_on;
  logic [11:0] i_addr;
  logic [31:0] i_wdata, o_rdata, rdv;
  logic        carrier, ir_pin, rx_pwr, irq_e, irq_s, irq_r, irq_f;
  int          n_mismatch = 0;
  int          n_compared = 0;
  int          hi_ir, ri_ir, hi_pw, ri_pw;
  // Pulse cases: prescale, flags, period, on time, holding word
  logic [47:0] pcfg [5] = '{48'h0010_0301_8200, 48'h0010_0301_8103,
    48'h0010_0402_8181, 48'h0018_0301_8200, 48'h0110_0301_8200};
  int          ehi [5] = '{40, 15, 96, 200, 40};
  int          eri [5] = '{40, 15, 48, 40, 20};
  irpc_top #(.SLOW_DIV(4)) dut_u (
    .i_clk(i_clk), .i_reset_n(i_reset_n), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_carrier_present_input(carrier), .i_slow_clk(i_slow_clk),
    .o_ir_output_pin(ir_pin), .o_receiver_power_pin(rx_pwr),
    .o_holding_empty_irq(irq_e), .o_carrier_sample_irq(irq_s),
    .o_carrier_rise_irq(irq_r), .o_carrier_fall_irq(irq_f));
  irpc_ir_front fe_u (.i_clk(i_clk), .i_rx_pwr(rx_pwr),
    .i_carrier_on(carrier_on), .o_carrier(carrier));
  // ==========================================================
  // Clocks; slow clock edges fall on even ns, never on a rising clock edge
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  initial begin
    i_slow_clk = 1'b0;
    forever #36 i_slow_clk = ~i_slow_clk;
  end
  // ==========================================================
  // Bus and checking tasks
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 rdv = o_rdata;
    check(rdv, exp, "read data");
  endtask
  // Counts high cycles and rising edges of both pins
  task automatic window(input int n);
    logic pi, pp;
    // Step off the edge so the first previous value is settled
    #1;
    pi = ir_pin;
    pp = rx_pwr;
    hi_ir = 0;
    ri_ir = 0;
    hi_pw = 0;
    ri_pw = 0;
    repeat (n) begin
      @(posedge i_clk);
      #1;
      hi_ir += int'(ir_pin === 1'b1);
      ri_ir += int'(ir_pin === 1'b1 && pi !== 1'b1);
      hi_pw += int'(rx_pwr === 1'b1);
      ri_pw += int'(rx_pwr === 1'b1 && pp !== 1'b1);
      pi = ir_pin;
      pp = rx_pwr;
    end
  endtask
  task automatic tally_and_finish;
    $display("counts: %0d compared, %0d mismatched", n_compared,
             n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #200000;
    n_mismatch++;
    $display("ERROR %0t: watchdog expired", $time);
    tally_and_finish;
  end
  // ==========================================================
  // Main sequence
  initial begin
    i_reset_n = 1'b0;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_addr = 12'h000;
    i_wdata = 32'h0000_0000;
    carrier_on = 1'b0;
    repeat (4) @(posedge i_clk);
    i_reset_n <= 1'b1;
    repeat (3) @(posedge i_clk);
    rchk(irpc_pkg::OFS_CTRL_ONE, 32'h0000_0000);
    rchk(irpc_pkg::OFS_CTRL_TWO, 32'h0000_0000);
    rchk(12'h0b0, 32'h0000_0000);
    rchk(irpc_pkg::OFS_STATUS, 32'h0000_0000);
    check({31'h0, ir_pin}, 32'h0000_0000, "idle pin");
    $display("test reset values done");
    foreach (pcfg[i]) begin
      wr(irpc_pkg::OFS_CTRL_ONE, {24'h0, pcfg[i][39:32]});
      repeat (4) @(posedge i_clk);
      check({31'h0, ir_pin}, {31'h0, pcfg[i][35]}, "off pin");
      wr(irpc_pkg::OFS_STATUS, 32'h0000_0001);
      rchk(irpc_pkg::OFS_STATUS, 32'h0000_0000);
      wr(irpc_pkg::OFS_CTRL_TWO, {pcfg[i][31:16], 16'h0});
      wr(irpc_pkg::OFS_HOLD, {16'h0, pcfg[i][15:0]});
      wr(irpc_pkg::OFS_CTRL_ONE,
         {8'h0, pcfg[i][47:40], 8'h0, pcfg[i][39:32] | 8'h01});
      wr(irpc_pkg::OFS_HOLD, {16'h0, pcfg[i][15:0]});
      repeat (40) @(posedge i_clk);
      window(240);
      check(32'(hi_ir), 32'(ehi[i]), "pin high cycles");
      check(32'(ri_ir), 32'(eri[i]), "pulse count");
      check({31'h0, irq_e}, 32'h0000_0001, "empty flag");
      $display("test pulse case %0d done", i);
    end
    wr(irpc_pkg::OFS_CTRL_TWO, 32'h0000_0701);
    carrier_on <= 1'b1;
    wr(irpc_pkg::OFS_CTRL_ONE, 32'h0000_0012);
    repeat (40) @(posedge i_clk);
    window(240);
    check(32'(hi_pw), 32'd120, "power cycles");
    check(32'(ri_pw), 32'd15, "power count");
    rchk(irpc_pkg::OFS_STATUS, 32'h0000_000F);
    wr(irpc_pkg::OFS_CTRL_ONE, 32'h0000_0010);
    repeat (8) @(posedge i_clk);
    check({31'h0, rx_pwr}, 32'h0000_0000, "power off");
    wr(irpc_pkg::OFS_STATUS, 32'h0000_000F);
    rchk(irpc_pkg::OFS_STATUS, 32'h0000_0000);
    carrier_on <= 1'b0;
    wr(irpc_pkg::OFS_CTRL_ONE, 32'h0000_0012);
    repeat (64) @(posedge i_clk);
    rchk(irpc_pkg::OFS_STATUS, 32'h0000_0000);
    wr(irpc_pkg::OFS_CTRL_ONE, 32'h0000_0010);
    $display("test carrier machine done");
    carrier_on <= 1'b1;
    wr(irpc_pkg::OFS_CTRL_ONE, 32'h0000_0014);
    repeat (10) @(posedge i_clk);
    check({31'h0, rx_pwr}, 32'h0000_0001, "manual power");
    rchk(irpc_pkg::OFS_CTRL_ONE, 32'h0100_0014);
    rchk(irpc_pkg::OFS_STATUS, 32'h0000_0004);
    wr(irpc_pkg::OFS_CTRL_ONE, 32'h0000_0010);
    repeat (10) @(posedge i_clk);
    rchk(irpc_pkg::OFS_STATUS, 32'h0000_000C);
    $display("test carrier edges done");
    wr(irpc_pkg::OFS_CTRL_TWO, 32'h0101_0000);
    wr(irpc_pkg::OFS_HOLD, 32'h0000_8181);
    wr(irpc_pkg::OFS_CTRL_ONE, 32'h0000_0001);
    repeat (100) @(posedge i_clk);
    // 1357 cycles hold 50 or 51 baud ticks, one pulse per two
    window(1357);
    check(32'(ri_ir >= 25 && ri_ir <= 26), 32'd1, "baud pulses");
    $display("test baud tick done");
    wr(irpc_pkg::OFS_CTRL_TWO, 32'h0000_0001);
    wr(irpc_pkg::OFS_CTRL_ONE, 32'h0000_0002);
    repeat (200) @(posedge i_clk);
    // 2304 cycles are exactly 40 power periods of eight slow edges
    window(2304);
    check(32'(ri_pw), 32'd40, "slow power count");
    check(32'(hi_pw), 32'd1152, "slow power cycles");
    $display("test slow tick done");
    tally_and_finish;
  end
endmodule
`default_nettype wire
